/* scc_map.svh */
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_CLK_MHZ 100
`define SCC_START_WN_MS 30
`define SCC_START_WN_CYC (`SCC_START_WN_MS * 1000 * `SCC_CLK_MHZ)
`define SCC_SETTLE_US 100
`define SCC_SETTLE_CYC (`SCC_SETTLE_US * `SCC_CLK_MHZ)
`define SCC_WDOG_CYC 1000000
`define SCC_ADDR_MODE 4'h0
`define SCC_ADDR_CFG 4'h1
`define SCC_ADDR_STAT 4'h2
`define SCC_ADDR_BRIDGE 4'h3
`define SCC_ADDR_TEMP1 4'h4
`define SCC_ADDR_TEMP2 4'h5
`define SCC_ADDR_CMD 4'h6
`define SCC_CMD_EXIT 16'h0001
`define SCC_CMD_CLEAR 16'h0002
`define SCC_SIGNATURE 16'ha5c3
`define SCC_CFG_OUT_LSB 0
`define SCC_CFG_DIAG_EN 2
`define SCC_CFG_SAME_TS 3
`define SCC_CFG_SLEEP 4
`define SCC_CFG_BCC_EN 5
`endif

/* scc_pkg.sv */
package scc_pkg;
    typedef enum logic [1:0] {SCC_OUT_LIN, SCC_OUT_HSS, SCC_OUT_LSS, SCC_OUT_BAD} scc_out_t;
    typedef enum logic [2:0] {
        SCC_MUX_BRIDGE, SCC_MUX_CAL_TEMP, SCC_MUX_MEAS_TEMP, SCC_MUX_AZ, SCC_MUX_DIAG
    } scc_mux_t;
    typedef enum logic [2:0] {
        SCC_ST_POR, SCC_ST_LOAD, SCC_ST_START, SCC_ST_NORMAL, SCC_ST_COMMAND, SCC_ST_DIAG
    } scc_state_t;
endpackage

/* scc_meas_if.sv */
`timescale 1ns/1ns
interface scc_meas_if;
    import scc_pkg::*;
    logic step;
    logic adc_valid;
    logic [15:0] adc_data;
    logic [15:0] az_value;
    logic [14:0] bridge_out;
    logic [14:0] temp1_out;
    logic [14:0] temp2_out;
    scc_mux_t mux_sel;
    logic cycle_done;
    logic diag_fail;
    modport ctrl (output step, output adc_valid, output adc_data, input mux_sel,
        input bridge_out, input temp1_out, input temp2_out, input cycle_done,
        input diag_fail, input az_value);
    modport seq (input step, input adc_valid, input adc_data, output mux_sel,
        output bridge_out, output temp1_out, output temp2_out, output cycle_done,
        output diag_fail, output az_value);
endinterface

/* scc_meas_seq.sv */
`timescale 1ns/1ns
module scc_meas_seq
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic lin_mode,
    input wire logic same_sensor,
    scc_meas_if.seq m
);
    typedef struct packed {
        scc_mux_t mux;
        logic [15:0] az;
        logic [14:0] bridge;
        logic [14:0] t1;
        logic [14:0] t2;
        logic done;
        logic fail;
    } scc_seq_t;
    scc_seq_t s_reg, s_next;

    // Auto-zero subtract and clamp into the positive 15-bit range
    function automatic logic [14:0] norm15(input logic [15:0] raw, input logic [15:0] az);
        logic [16:0] d;
        d = {1'b0, raw} - {1'b0, az};
        if (d[16]) norm15 = 15'h0000;
        else if (d[15]) norm15 = 15'h7fff;
        else norm15 = d[14:0];
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (m.step && m.adc_valid) begin
            unique case (s_reg.mux)
                SCC_MUX_BRIDGE: begin
                    s_next.bridge = norm15(m.adc_data, s_reg.az);
                    s_next.mux = SCC_MUX_CAL_TEMP;
                end
                SCC_MUX_CAL_TEMP: begin
                    s_next.t1 = norm15(m.adc_data, s_reg.az);
                    // Second temperature only in LIN mode
                    s_next.mux = lin_mode ? SCC_MUX_MEAS_TEMP : SCC_MUX_AZ;
                end
                SCC_MUX_MEAS_TEMP: begin
                    s_next.t2 = same_sensor ? s_reg.t1 : norm15(m.adc_data, s_reg.az);
                    s_next.mux = SCC_MUX_AZ;
                end
                SCC_MUX_AZ: begin
                    s_next.az = m.adc_data;
                    s_next.mux = SCC_MUX_DIAG;
                end
                default: begin
                    // Connection, short, aging checks every cycle regardless of enable
                    s_next.fail = m.adc_data[15];
                    s_next.done = 1'b1;
                    s_next.mux = SCC_MUX_BRIDGE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign m.mux_sel = s_reg.mux;
    assign m.az_value = s_reg.az;
    assign m.bridge_out = s_reg.bridge;
    assign m.temp1_out = s_reg.t1;
    assign m.temp2_out = s_reg.t2;
    assign m.cycle_done = s_reg.done;
    assign m.diag_fail = s_reg.fail;
endmodule

/* scc_sys_ctrl.sv */
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "scc_map.svh"
module scc_sys_ctrl
    import scc_pkg::*;
#(
    parameter int START_WN_CYC = `SCC_START_WN_CYC,
    parameter int SETTLE_CYC = `SCC_SETTLE_CYC,
    parameter int WDOG_CYC = `SCC_WDOG_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic osc_ok,
    input wire logic mem_fault,
    input wire logic bcc_fail,
    input wire logic nvm_valid,
    input wire logic [15:0] nvm_signature,
    input wire logic [7:0] nvm_config,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    input wire logic lin_rx,
    input wire logic high_side_rx,
    input wire logic low_side_rx,
    input wire logic cmd_frame_done,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [2:0] mux_sel,
    output logic nvm_read,
    output logic link_rx,
    output logic [2:0] link_src,
    output logic lin_tx_en,
    output logic high_side_en,
    output logic low_side_en,
    output logic resistive_out,
    output logic lin_sleep_en,
    output logic [1:0] mode,
    output logic [3:0] status
);
    typedef struct packed {
        scc_state_t st;
        logic [31:0] cnt;
        logic [31:0] wdog;
        logic [7:0] cfg;
        logic [3:0] stat;
        logic [15:0] rdata;
        logic [2:0] mux;
        logic nvm_rd;
        logic first_done;
        logic rx;
        logic [2:0] src;
        logic lin_en;
        logic hs_en;
        logic ls_en;
        logic resist;
        logic sleep;
        logic [1:0] mode;
        logic [2:0] rx_s1;
        logic [2:0] rx_s2;
        logic [2:0] fl_s1;
        logic [2:0] fl_s2;
    } scc_ctrl_t;
    scc_ctrl_t r_reg, r_next;

    scc_meas_if mi();
    logic lin_mode;
    logic step;
    scc_out_t out_sel;

    assign out_sel = scc_out_t'(r_reg.cfg[`SCC_CFG_OUT_LSB +: 2]);
    assign lin_mode = (out_sel == SCC_OUT_LIN);
    assign step = (r_reg.st == SCC_ST_START) || (r_reg.st == SCC_ST_NORMAL);
    assign mi.step = step;
    assign mi.adc_valid = adc_valid;
    assign mi.adc_data = adc_data;

    scc_meas_seq u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .lin_mode(lin_mode),
        .same_sensor(r_reg.cfg[`SCC_CFG_SAME_TS]),
        .m(mi.seq)
    );

    // Register read mux shared by all states
    function automatic logic [15:0] rd_mux(input logic [3:0] a, input scc_ctrl_t r,
        input logic [14:0] b, input logic [14:0] t1, input logic [14:0] t2);
        unique case (a)
            `SCC_ADDR_MODE: rd_mux = {14'h0000, r.mode};
            `SCC_ADDR_CFG: rd_mux = {8'h00, r.cfg};
            `SCC_ADDR_STAT: rd_mux = {12'h000, r.stat};
            `SCC_ADDR_BRIDGE: rd_mux = {1'b0, b};
            `SCC_ADDR_TEMP1: rd_mux = {1'b0, t1};
            `SCC_ADDR_TEMP2: rd_mux = {1'b0, t2};
            default: rd_mux = 16'h0000;
        endcase
    endfunction

    // Drivers for each mode: only the selected output may ever drive
    function automatic logic [2:0] drv(input scc_out_t o);
        unique case (o)
            SCC_OUT_LIN: drv = 3'h1;
            SCC_OUT_HSS: drv = 3'h2;
            SCC_OUT_LSS: drv = 3'h4;
            default: drv = 3'h0;
        endcase
    endfunction

    logic [2:0] rx_now;
    logic [2:0] fail_now;
    logic fault;
    logic [2:0] act;

    always_comb begin
        r_next = r_reg;
        // Two-flop synchronisers for pins and asynchronous monitors
        r_next.rx_s1 = {low_side_rx, ~high_side_rx, lin_rx};
        r_next.rx_s2 = r_reg.rx_s1;
        r_next.fl_s1 = {~osc_ok, mem_fault, bcc_fail};
        r_next.fl_s2 = r_reg.fl_s1;
        rx_now = r_reg.rx_s2;
        fail_now = r_reg.fl_s2;
        r_next.nvm_rd = 1'b0;
        r_next.rdata = 16'h0000;
        act = drv(out_sel);
        r_next.src = 3'h0;
        r_next.rx = 1'b1;
        r_next.wdog = r_reg.wdog + 32'd1;
        if (mi.cycle_done) begin
            r_next.wdog = 32'd0;
        end
        if (reg_rd) begin
            r_next.rdata = rd_mux(reg_addr, r_reg, mi.bridge_out, mi.temp1_out, mi.temp2_out);
        end
        fault = fail_now[2] || fail_now[1] || (r_reg.wdog >= WDOG_CYC);
        // Sensor checks report even with diagnostic processing switched off
        fault = fault || mi.diag_fail;
        unique case (r_reg.st)
            SCC_ST_POR: begin
                // Hold internal reset until the supply has been good long enough
                r_next.cnt = supply_ok ? r_reg.cnt + 32'd1 : 32'd0;
                if (r_reg.cnt >= SETTLE_CYC) begin
                    r_next.st = SCC_ST_LOAD;
                    r_next.cnt = 32'd0;
                    r_next.nvm_rd = 1'b1;
                end
            end
            SCC_ST_LOAD: begin
                if (nvm_valid) begin
                    r_next.cfg = nvm_config;
                    r_next.cnt = 32'd0;
                    r_next.wdog = 32'd0;
                    // Broken signature or broken chip goes straight to diagnostics
                    if (nvm_signature != `SCC_SIGNATURE) begin
                        r_next.st = SCC_ST_DIAG;
                        r_next.stat[0] = 1'b1;
                    end else if (nvm_config[`SCC_CFG_BCC_EN] && fail_now[0]) begin
                        r_next.st = SCC_ST_DIAG;
                        r_next.stat[1] = 1'b1;
                    end else begin
                        r_next.st = SCC_ST_START;
                    end
                end
            end
            SCC_ST_START: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                r_next.lin_en = 1'b0;
                r_next.hs_en = 1'b0;
                r_next.ls_en = 1'b0;
                r_next.src = rx_now;
                r_next.rx = &rx_now;
                if (mi.cycle_done) r_next.first_done = 1'b1;
                if (cmd_frame_done) begin
                    r_next.st = SCC_ST_COMMAND;
                end else if (r_reg.cnt >= START_WN_CYC - 1) begin
                    r_next.st = SCC_ST_NORMAL;
                    r_next.lin_en = act[0];
                    r_next.hs_en = act[1];
                    r_next.ls_en = act[2];
                    // PWM cannot work with sleep enabled
                    r_next.sleep = lin_mode && r_reg.cfg[`SCC_CFG_SLEEP];
                end
            end
            SCC_ST_NORMAL: begin
                if (lin_mode) begin
                    r_next.src = {2'b00, rx_now[0]};
                    r_next.rx = rx_now[0];
                end
                if (fault) begin
                    r_next.st = SCC_ST_DIAG;
                    r_next.stat[3] = r_reg.stat[3] || fail_now[2];
                    r_next.stat[2] = r_reg.stat[2] || fail_now[1] || mi.diag_fail;
                    r_next.stat[1] = r_reg.stat[1] || (r_reg.wdog >= WDOG_CYC);
                    r_next.hs_en = 1'b0;
                    r_next.ls_en = 1'b0;
                    r_next.resist = !lin_mode;
                end
            end
            SCC_ST_COMMAND: begin
                // Config and command registers writable by software only here
                if (reg_wr && reg_addr == `SCC_ADDR_CFG) begin
                    r_next.cfg = reg_wdata[7:0];
                end
                if (reg_wr && reg_addr == `SCC_ADDR_CMD && reg_wdata == `SCC_CMD_CLEAR) begin
                    r_next.stat = 4'h0;
                end
                if (reg_wr && reg_addr == `SCC_ADDR_CMD && reg_wdata == `SCC_CMD_EXIT) begin
                    r_next.st = SCC_ST_NORMAL;
                    r_next.lin_en = act[0];
                    r_next.hs_en = act[1];
                    r_next.ls_en = act[2];
                    r_next.sleep = lin_mode && r_reg.cfg[`SCC_CFG_SLEEP];
                end
                r_next.wdog = 32'd0;
                r_next.src = rx_now;
            end
            SCC_ST_DIAG: begin
                // LIN stays reachable so a master can read the status bits
                r_next.lin_en = act[0];
                r_next.hs_en = 1'b0;
                r_next.ls_en = 1'b0;
                r_next.resist = !lin_mode;
                r_next.wdog = 32'd0;
                if (lin_mode) r_next.src = {2'b00, rx_now[0]};
            end
            default: r_next.st = SCC_ST_POR;
        endcase
        r_next.mux = mi.mux_sel;
        r_next.mode = (r_next.st == SCC_ST_COMMAND) ? 2'h1 :
            (r_next.st == SCC_ST_DIAG) ? 2'h2 : 2'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign mux_sel = r_reg.mux;
    assign nvm_read = r_reg.nvm_rd;
    assign link_rx = r_reg.rx;
    assign link_src = r_reg.src;
    assign lin_tx_en = r_reg.lin_en;
    assign high_side_en = r_reg.hs_en;
    assign low_side_en = r_reg.ls_en;
    assign resistive_out = r_reg.resist;
    assign lin_sleep_en = r_reg.sleep;
    assign mode = r_reg.mode;
    assign status = r_reg.stat;
endmodule

/* scc_sys_ctrl_assertions.sv */
`timescale 1ns/1ns
module scc_sys_ctrl_assertions #(
    parameter int START_WN_CYC = 200,
    parameter int SETTLE_CYC = 10
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic osc_ok,
    input wire logic nvm_valid,
    input wire logic [7:0] nvm_config,
    input wire logic cmd_frame_done,
    input wire logic nvm_read,
    input wire logic lin_tx_en,
    input wire logic high_side_en,
    input wire logic low_side_en,
    input wire logic resistive_out,
    input wire logic [1:0] mode,
    input wire logic [3:0] status
);
    logic [15:0] sup_reg;
    logic [15:0] win_reg;
    logic [2:0] en;
    logic [2:0] en_exp;
    assign en = {lin_tx_en, high_side_en, low_side_en};
    assign en_exp = 3'h4 >> nvm_config[1:0];
    // Window count parks one past the end so the expiry check fires once only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_reg <= 16'h0000;
            win_reg <= 16'h0000;
        end else begin
            sup_reg <= supply_ok ? sup_reg + 16'h0001 : 16'h0000;
            if (nvm_valid) begin
                win_reg <= 16'h0001;
            end else if (win_reg != 16'h0000 && win_reg <= 16'(START_WN_CYC)) begin
                win_reg <= win_reg + 16'h0001;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ONE_OUTPUT: assert property ($onehot0(en))
        else $error("two outputs enabled");
    AST_OUT_CFG: assert property (en != 3'h0 |-> en == en_exp)
        else $error("wrong output enabled");
    AST_WIN_TRISTATE: assert property (win_reg != 0 && win_reg < START_WN_CYC |-> en == 3'h0)
        else $error("driver on in start window");
    AST_WIN_EXPIRY: assert property (win_reg == START_WN_CYC && mode == 2'h0 && status == 4'h0
        |-> ##[1:4] en == en_exp)
        else $error("no output after window");
    AST_CMD_ENTRY: assert property (cmd_frame_done && win_reg > 1 && win_reg < START_WN_CYC - 2
        && mode == 2'h0 |-> ##[1:3] mode == 2'h1)
        else $error("command entry missed");
    AST_SETTLE: assert property ($rose(nvm_read) |-> sup_reg >= SETTLE_CYC - 1)
        else $error("config read before supply settled");
    AST_PWM_RESISTIVE: assert property (mode == 2'h2 && ^nvm_config[1:0]
        |-> ##[0:2] resistive_out)
        else $error("pwm output not resistive in diag");
    AST_OSC_FLAG: assert property ($fell(osc_ok) |-> ##[1:6] status[3])
        else $error("oscillator fault not flagged");
    COV_CMD: cover property (mode == 2'h1);
    COV_DIAG_PWM: cover property (mode == 2'h2 && resistive_out);
    COV_LIN_ON: cover property (en == 3'h4);
endmodule

/* scc_tool_model.sv */
`timescale 1ns/1ns
module scc_tool_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic hold,
    input wire logic [1:0] pin,
    output logic lin_rx,
    output logic high_side_rx,
    output logic low_side_rx,
    output logic cmd_frame_done
);
    logic [3:0] bit_reg;
    logic lvl;
    // LIN level on the chosen pin, 0 dominant except on the inverted high side; idle pins rest recessive
    assign lvl = ~hold & ((bit_reg == 4'h0) | bit_reg[0]);
    assign lin_rx = (pin == 2'h0) ? lvl : 1'b1;
    assign high_side_rx = (pin == 2'h1) ? ~lvl : 1'b0;
    assign low_side_rx = (pin == 2'h2) ? lvl : 1'b1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_reg <= 4'h0;
            cmd_frame_done <= 1'b0;
        end else begin
            // Decoder flags the entry frame once its last bit is in
            cmd_frame_done <= (bit_reg == 4'h9);
            if (go) begin
                bit_reg <= 4'h1;
            end else if (bit_reg != 4'h0) begin
                bit_reg <= (bit_reg == 4'h9) ? 4'h0 : bit_reg + 4'h1;
            end
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/1ns
`include "scc_map.svh"
module tb;
    import scc_pkg::*;
    localparam int START_WN = 200;
    logic clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b0, osc_ok = 1'b1, nvm_valid = 1'b0;
    logic adc_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, hold = 1'b0;
    logic diag_bad = 1'b0;
    logic [1:0] pin = 2'h0, adc_cnt = 2'h0, mode;
    logic [3:0] reg_addr = 4'h0, status;
    logic [7:0] nvm_cfg = 8'h00, seen;
    logic [15:0] nvm_sig = 16'h0000, adc_data = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rd;
    logic lin_rx, high_side_rx, low_side_rx, cmd_frame_done, nvm_read, link_rx;
    logic lin_tx_en, high_side_en, low_side_en, resistive_out, lin_sleep_en;
    logic [2:0] mux_sel, link_src, en;
    int err_total = 0, checked = 0, cyc = 0;
    assign en = {lin_tx_en, high_side_en, low_side_en};
    always #5 clk = ~clk;
    scc_sys_ctrl #(.START_WN_CYC(START_WN), .SETTLE_CYC(10), .WDOG_CYC(500)) dut (
        .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .osc_ok(osc_ok), .mem_fault(1'b0),
        .bcc_fail(1'b0), .nvm_valid(nvm_valid), .nvm_signature(nvm_sig), .nvm_config(nvm_cfg),
        .adc_valid(adc_valid), .adc_data(adc_data), .lin_rx(lin_rx),
        .high_side_rx(high_side_rx), .low_side_rx(low_side_rx), .cmd_frame_done(cmd_frame_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mux_sel(mux_sel), .nvm_read(nvm_read), .link_rx(link_rx),
        .link_src(link_src), .lin_tx_en(lin_tx_en), .high_side_en(high_side_en),
        .low_side_en(low_side_en), .resistive_out(resistive_out), .lin_sleep_en(lin_sleep_en),
        .mode(mode), .status(status));
    scc_tool_model tool (.clk(clk), .rst_n(rst_n), .go(go), .hold(hold), .pin(pin),
        .lin_rx(lin_rx), .high_side_rx(high_side_rx), .low_side_rx(low_side_rx),
        .cmd_frame_done(cmd_frame_done));
    // Converter stand-in: a result every fourth cycle; the diag slot may be made to fail
    always @(posedge clk) begin
        cyc <= cyc + 1;
        adc_cnt <= adc_cnt + 2'h1;
        adc_valid <= (adc_cnt == 2'h3);
        adc_data <= (diag_bad && mux_sel == SCC_MUX_DIAG) ? 16'h8000 : 16'h0400;
        seen <= rst_n ? (seen | (8'h01 << mux_sel)) : 8'h00;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("errors %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Bounded wait for a mode, or for any output driver when want_en is set
    task automatic wait_for(input logic [1:0] m, input bit want_en);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (want_en ? (en !== 3'h0) : (mode === m)) break;
        end
    endtask
    task automatic do_reset(input logic [7:0] cfg, input logic [15:0] sig);
        @(posedge clk);
        rst_n <= 1'b0;
        supply_ok <= 1'b0;
        osc_ok <= 1'b1;
        diag_bad <= 1'b0;
        nvm_cfg <= cfg;
        nvm_sig <= sig;
        step(8);
        rst_n <= 1'b1;
        supply_ok <= 1'b1;
        for (int i = 0; i < 60 && nvm_read !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0000, nvm_read}, 16'h0001);
        @(posedge clk);
        nvm_valid <= 1'b1;
        @(posedge clk);
        nvm_valid <= 1'b0;
    endtask
    // Hold one pin dominant and watch the merged receive line
    task automatic pin_low(input logic [1:0] p);
        @(posedge clk);
        pin <= p;
        hold <= 1'b1;
        step(6);
        #1 chk({15'h0000, link_rx}, 16'h0000);
        @(posedge clk);
        hold <= 1'b0;
    endtask
    task automatic t_outputs();
        for (int o = 0; o < 3; o++) begin
            do_reset(8'h10 | 8'(o), `SCC_SIGNATURE);
            step(START_WN / 2);
            #1 chk({13'h0000, en}, 16'h0000);
            wait_for(2'h0, 1'b1);
            chk({13'h0000, en}, 16'h0004 >> o);
            chk({14'h0000, mode}, 16'h0000);
            chk({15'h0000, lin_sleep_en}, (o == 0) ? 16'h0001 : 16'h0000);
            if (o == 0) pin_low(2'h0);
        end
    endtask
    task automatic t_cmd();
        for (int p = 0; p < 3; p++) begin
            do_reset(8'h01, `SCC_SIGNATURE);
            step(10);
            pin_low(2'(p));
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wait_for(2'h1, 1'b0);
            reg_read(4'h0, rd);
            chk(rd, 16'h0001);
            reg_write(4'h1, 16'h0009);
            step(START_WN);
            reg_write(4'h6, `SCC_CMD_EXIT);
            reg_read(4'h1, rd);
            chk(rd, 16'h0009);
            chk({13'h0000, en}, 16'h0002);
            reg_write(4'h1, 16'h00ff);
            reg_read(4'h1, rd);
            chk(rd, 16'h0009);
            reg_read(4'hf, rd);
            chk(rd, 16'h0000);
        end
    endtask
    task automatic t_faults();
        do_reset(8'h02, ~`SCC_SIGNATURE);
        wait_for(2'h2, 1'b0);
        chk({14'h0000, mode}, 16'h0002);
        // The resistive switch follows one cycle after the mode change
        step(1);
        #1 chk({15'h0000, resistive_out}, 16'h0001);
        reg_read(4'h2, rd);
        chk(rd, 16'h0001);
        // Diagnostics processing left off: the sensor checks must still run
        do_reset(8'h02, `SCC_SIGNATURE);
        wait_for(2'h0, 1'b1);
        @(posedge clk);
        diag_bad <= 1'b1;
        step(100);
        reg_read(4'h2, rd);
        chk(rd & 16'h0004, 16'h0004);
        chk({8'h00, seen}, 16'h001b);
        do_reset(8'h00, `SCC_SIGNATURE);
        wait_for(2'h0, 1'b1);
        chk({8'h00, seen}, 16'h001f);
        @(posedge clk);
        osc_ok <= 1'b0;
        wait_for(2'h2, 1'b0);
        chk({14'h0000, mode}, 16'h0002);
        reg_read(4'h2, rd);
        chk(rd & 16'h0008, 16'h0008);
    endtask
    initial begin
        t_outputs();
        t_cmd();
        t_faults();
        close_out();
    end
endmodule
bind scc_sys_ctrl scc_sys_ctrl_assertions #(.START_WN_CYC(START_WN_CYC),
    .SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .osc_ok(osc_ok), .nvm_valid(nvm_valid), .nvm_config(nvm_config),
    .cmd_frame_done(cmd_frame_done), .nvm_read(nvm_read), .lin_tx_en(lin_tx_en),
    .high_side_en(high_side_en), .low_side_en(low_side_en), .resistive_out(resistive_out),
    .mode(mode), .status(status));
